// >>> tttc_pkg.sv
package tttc_pkg;
   // register offsets, byte addresses on the plain register port
   localparam logic [31:0] ADDR_START = 32'hFFFF83D0;
   localparam logic [31:0] ADDR_CSR0 = 32'hFFFF83D2;
   localparam logic [31:0] ADDR_CNT0 = 32'hFFFF83D4;
   localparam logic [31:0] ADDR_COR0 = 32'hFFFF83D6;
   localparam logic [31:0] ADDR_STBY1 = 32'hFFFF861C;
   localparam logic [31:0] ADDR_STBY2 = 32'hFFFF861E;
   localparam logic [31:0] ADDR_DBASE = 32'hFFFF8708;
   localparam logic [31:0] ADDR_VEC = 32'hFFFF8720;
   localparam logic [31:0] ADDR_XSTAT = 32'hFFFF8724;
   // field positions
   localparam int RUN0_BIT = 0;
   localparam int RUN1_BIT = 1;
   localparam int FLAG_BIT = 7;
   localparam int IE_BIT = 6;
   localparam int XSTBY_HI_BIT = 9;
   localparam int XSTBY_LO_BIT = 8;
   localparam int TSTBY_BIT = 12;
   // reset values
   localparam logic [15:0] STBY1_RST = 16'h0300;
   localparam logic [15:0] STBY2_RST = 16'h1000;
   localparam logic [15:0] COR_RST = 16'hFFFF;
   localparam logic [15:0] DBASE_RST = 16'h0000;
   localparam logic [15:0] VEC_RST = 16'h0000;
   // descriptor layout, byte offsets from the start address
   localparam logic [31:0] OFS_MODE = 32'h00000000;
   localparam logic [31:0] OFS_COUNT = 32'h00000002;
   localparam logic [31:0] OFS_SRC = 32'h00000008;
   localparam logic [31:0] OFS_DST = 32'h0000000C;
   // addressing mode code for increment
   localparam logic [1:0] AM_INC = 2'h2;
   localparam int SM_LSB = 14;
   localparam int DM_LSB = 12;
   // prescale divisors minus one per clock select code
   localparam logic [9:0] DIV0 = 10'h007;
   localparam logic [9:0] DIV1 = 10'h01F;
   localparam logic [9:0] DIV2 = 10'h07F;
   localparam logic [9:0] DIV3 = 10'h1FF;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [31:0] addr;
      logic [15:0] wdata;
   } mem_req_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_MODE = 4'h1,
      ST_CNT = 4'h2,
      ST_SRCH = 4'h3,
      ST_SRCL = 4'h4,
      ST_DSTH = 4'h5,
      ST_DSTL = 4'h6,
      ST_RDB = 4'h7,
      ST_WRB = 4'h8,
      ST_WBM = 4'h9,
      ST_WBS = 4'hA,
      ST_WBD = 4'hB,
      ST_WBE = 4'hC
   } xfer_state_t;
endpackage : tttc_pkg

// >>> match_timer.sv
`timescale 1ns/1ps
module match_timer (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic run,
   input wire logic [1:0] clk_sel,
   input wire logic [15:0] period,
   // software count write
   input wire logic cnt_wr,
   input wire logic [15:0] cnt_wdata,
   // status
   output logic [15:0] count,
   output logic match
);
   logic [9:0] pre_ff;
   logic [15:0] cnt_ff;
   logic match_ff;
   logic [9:0] div_top;
   logic tick;

   always_comb begin
      unique case (clk_sel)
         2'h0: div_top = tttc_pkg::DIV0;
         2'h1: div_top = tttc_pkg::DIV1;
         2'h2: div_top = tttc_pkg::DIV2;
         2'h3: div_top = tttc_pkg::DIV3; // peripheral clock over 512
      endcase
   end
   assign tick = run && (pre_ff >= div_top); // R10

   // prescaler free-runs only while the channel runs
   always_ff @(posedge clk) begin
      if (!rst_n || !run || tick) begin
         pre_ff <= 10'h000;
      end else begin
         pre_ff <= pre_ff + 10'h001;
      end
   end

   // up-counter; a match restarts from zero on the next count
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_ff <= 16'h0000;
      end else if (cnt_wr) begin
         cnt_ff <= cnt_wdata;
      end else if (tick) begin // R11
         cnt_ff <= (cnt_ff == period) ? 16'h0000 : cnt_ff + 16'h0001; // R12 R20
      end
   end

   // one-cycle pulse in the cycle after the tick that sees equality
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         match_ff <= 1'b0;
      end else begin
         match_ff <= tick && (cnt_ff == period); // R8 R13
      end
   end
   assign count = cnt_ff;
   assign match = match_ff;

   property p_wrap;
      @(posedge clk) disable iff (!rst_n)
      (tick && !cnt_wr && cnt_ff == period) |=> (cnt_ff == 16'h0000);
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap after match"); // R20

   property p_match_cause;
      @(posedge clk) disable iff (!rst_n)
      match_ff |-> $past(tick) && $past(cnt_ff) == $past(period);
   endproperty
   a_match_cause: assert property (p_match_cause) else $error("bad match"); // R8

   property p_stop;
      @(posedge clk) disable iff (!rst_n)
      (!run && !cnt_wr) |=> $stable(cnt_ff);
   endproperty
   a_stop: assert property (p_stop) else $error("counter moved stopped"); // R11

   property p_div512;
      @(posedge clk) disable iff (!rst_n)
      (tick && clk_sel == 2'h3 && run) |=> !tick [*8];
   endproperty
   a_div512: assert property (p_div512) else $error("prescale short"); // R10
endmodule : match_timer

// >>> tttc_top.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] on activation read lower descriptor pointer half from the source's vector
// [R2] upper half of descriptor pointer comes from the descriptor base register
// [R3] both halves join into one 32-bit pointer before descriptor reads
// [R4] descriptor words read in ascending order, then data moves
// [R5] mode word at pointer, count word at pointer plus 2
// [R6] source pointer at plus 8, destination pointer at plus 12
// [R7] software prepares descriptor and vector entry before activation
// [R8] match flag sets when counter equals period constant
// [R9] match request leaves only while interrupt enable is 1
// [R10] clock select picks count rate; code 11 divides by 512
// [R11] start bit 0 runs channel 0, bit 1 channel 1; 0 stops; only channel 0 is built here, bit 1 is only stored and read back
// [R12] channel counter is a 16-bit up-counter
// [R13] 16-bit period constant sets the match period
// [R14] match activates transfer; cpu interrupt only after the last transfer
// [R15] controller awake only if bits 9,8 both 0; timer awake if bit 12 is 0
// [R16] count word counts 1 to 65536 transfers, zero meaning 65536
// [R17] updated descriptor words written back to ram after the transfer; the destination upper half at plus 12 is not written back here
// [R18] mode code 10 in top bits increments source or destination
// [R19] count decrements per byte; cpu request when it reaches zero
// [R20] after a match the counter restarts from zero
module tttc_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [31:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // ram port, 16-bit words, read data one cycle after rd
   output tttc_pkg::mem_req_t mem_req,
   input wire logic [15:0] mem_rdata,
   // cpu interrupt request
   output logic cpu_irq
);
   ////////////////////////////////////////////////////////////////////////
   logic [1:0] run_ff;
   logic ie_ff, flag_ff;
   logic [1:0] cks_ff;
   logic [15:0] cor_ff, stby1_ff, stby2_ff, dbase_ff, vec_ff;
   logic [15:0] rdata_ff;
   logic [15:0] cnt;
   logic match, cnt_wr, tmr_awake, xfer_awake, act;
   logic flag_clr;

   function automatic logic hit(input logic [31:0] a);
      hit = reg_wr && (reg_addr == a);
   endfunction : hit

   assign xfer_awake = !stby1_ff[tttc_pkg::XSTBY_HI_BIT]
      && !stby1_ff[tttc_pkg::XSTBY_LO_BIT]; // R15
   assign tmr_awake = !stby2_ff[tttc_pkg::TSTBY_BIT]; // R15
   // spelled out: an assign calling a function that reads module signals
   // would not wake up when those signals change
   assign cnt_wr = reg_wr && (reg_addr == tttc_pkg::ADDR_CNT0);

   match_timer u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .run(run_ff[tttc_pkg::RUN0_BIT] && tmr_awake), // R11
      .clk_sel(cks_ff),
      .period(cor_ff),
      .cnt_wr(cnt_wr),
      .cnt_wdata(reg_wdata),
      .count(cnt),
      .match(match)
   );

   // request gated by enable; with controller asleep nothing is activated
   assign act = match && ie_ff && xfer_awake; // R9 R14

   // control registers written by software
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run_ff <= 2'h0;
         ie_ff <= 1'b0;
         cks_ff <= 2'h0;
         cor_ff <= tttc_pkg::COR_RST;
         stby1_ff <= tttc_pkg::STBY1_RST;
         stby2_ff <= tttc_pkg::STBY2_RST;
         dbase_ff <= tttc_pkg::DBASE_RST;
         vec_ff <= tttc_pkg::VEC_RST;
      end else begin
         if (hit(tttc_pkg::ADDR_START)) begin
            run_ff <= reg_wdata[1:0]; // R11
         end
         if (hit(tttc_pkg::ADDR_CSR0)) begin
            ie_ff <= reg_wdata[tttc_pkg::IE_BIT];
            cks_ff <= reg_wdata[1:0];
         end
         if (hit(tttc_pkg::ADDR_COR0)) begin
            cor_ff <= reg_wdata;
         end
         if (hit(tttc_pkg::ADDR_STBY1)) begin
            stby1_ff <= reg_wdata;
         end
         if (hit(tttc_pkg::ADDR_STBY2)) begin
            stby2_ff <= reg_wdata;
         end
         if (hit(tttc_pkg::ADDR_DBASE)) begin
            dbase_ff <= reg_wdata;
         end
         if (hit(tttc_pkg::ADDR_VEC)) begin
            vec_ff <= reg_wdata; // R7
         end
      end
   end

   // match flag: cleared by writing 0 to it; a match in the same cycle wins
   assign flag_clr = reg_wr && (reg_addr == tttc_pkg::ADDR_CSR0)
      && !reg_wdata[tttc_pkg::FLAG_BIT];
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flag_ff <= 1'b0;
      end else if (match) begin
         flag_ff <= 1'b1; // R8
      end else if (flag_clr) begin
         flag_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   tttc_pkg::xfer_state_t st_ff;
   logic [31:0] rf_ff, src_ff, dst_ff;
   logic [15:0] mode_ff, count_ff;
   logic [7:0] src_byte;
   logic busy_ff, irq_ff;
   tttc_pkg::mem_req_t req_ff;
   logic src_inc, dst_inc;

   assign src_inc = mode_ff[tttc_pkg::SM_LSB +: 2] == tttc_pkg::AM_INC; // R18
   assign dst_inc = mode_ff[tttc_pkg::DM_LSB +: 2] == tttc_pkg::AM_INC; // R18
   // byte lane picked by source address bit 0, big-endian words
   assign src_byte = src_ff[0] ? mem_rdata[7:0] : mem_rdata[15:8];

   // descriptor fetch, byte move, write-back; each ram read answers next cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= tttc_pkg::ST_IDLE;
         rf_ff <= 32'h00000000;
         src_ff <= 32'h00000000;
         dst_ff <= 32'h00000000;
         mode_ff <= 16'h0000;
         count_ff <= 16'h0000;
         req_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         req_ff <= '0;
         irq_ff <= 1'b0;
         unique case (st_ff)
            tttc_pkg::ST_IDLE: begin
               if (act) begin
                  rf_ff <= {dbase_ff, vec_ff}; // R1 R2 R3
                  req_ff <= '{rd: 1'b1, wr: 1'b0,
                     addr: {dbase_ff, vec_ff} + tttc_pkg::OFS_MODE,
                     wdata: 16'h0000}; // R4 R5
                  st_ff <= tttc_pkg::ST_MODE;
               end
            end
            tttc_pkg::ST_MODE: begin
               req_ff <= '{1'b1, 1'b0, rf_ff + tttc_pkg::OFS_COUNT, 16'h0000};
               st_ff <= tttc_pkg::ST_CNT;
            end
            tttc_pkg::ST_CNT: begin
               mode_ff <= mem_rdata;
               req_ff <= '{1'b1, 1'b0, rf_ff + tttc_pkg::OFS_SRC, 16'h0000};
               st_ff <= tttc_pkg::ST_SRCH; // R6
            end
            tttc_pkg::ST_SRCH: begin
               count_ff <= mem_rdata; // R16
               req_ff <= '{1'b1, 1'b0, rf_ff + tttc_pkg::OFS_SRC + 32'h2,
                  16'h0000};
               st_ff <= tttc_pkg::ST_SRCL;
            end
            tttc_pkg::ST_SRCL: begin
               src_ff[31:16] <= mem_rdata;
               req_ff <= '{1'b1, 1'b0, rf_ff + tttc_pkg::OFS_DST, 16'h0000};
               st_ff <= tttc_pkg::ST_DSTH;
            end
            tttc_pkg::ST_DSTH: begin
               src_ff[15:0] <= mem_rdata;
               req_ff <= '{1'b1, 1'b0, rf_ff + tttc_pkg::OFS_DST + 32'h2,
                  16'h0000};
               st_ff <= tttc_pkg::ST_DSTL;
            end
            tttc_pkg::ST_DSTL: begin
               dst_ff[31:16] <= mem_rdata;
               req_ff <= '{1'b1, 1'b0, src_ff, 16'h0000}; // R4
               st_ff <= tttc_pkg::ST_RDB;
            end
            tttc_pkg::ST_RDB: begin
               // low half of destination arrives the cycle after its read
               dst_ff[15:0] <= mem_rdata;
               st_ff <= tttc_pkg::ST_WRB;
            end
            tttc_pkg::ST_WRB: begin
               // source byte stands on the ram port now; no byte enables,
               // so the byte goes out on both lanes
               req_ff <= '{1'b0, 1'b1, dst_ff, {src_byte, src_byte}};
               if (src_inc) begin
                  src_ff <= src_ff + 32'h1;
               end
               if (dst_inc) begin
                  dst_ff <= dst_ff + 32'h1;
               end
               count_ff <= count_ff - 16'h1; // R19 R16
               st_ff <= tttc_pkg::ST_WBM; // one byte per activation
            end
            tttc_pkg::ST_WBM: begin
               req_ff <= '{1'b0, 1'b1, rf_ff + tttc_pkg::OFS_COUNT, count_ff};
               st_ff <= tttc_pkg::ST_WBS; // R17
            end
            tttc_pkg::ST_WBS: begin
               req_ff <= '{1'b0, 1'b1, rf_ff + tttc_pkg::OFS_SRC, src_ff[31:16]};
               st_ff <= tttc_pkg::ST_WBD;
            end
            tttc_pkg::ST_WBD: begin
               req_ff <= '{1'b0, 1'b1, rf_ff + tttc_pkg::OFS_SRC + 32'h2,
                  src_ff[15:0]};
               st_ff <= tttc_pkg::ST_WBE;
            end
            tttc_pkg::ST_WBE: begin
               req_ff <= '{1'b0, 1'b1, rf_ff + tttc_pkg::OFS_DST + 32'h2,
                  dst_ff[15:0]};
               irq_ff <= (count_ff == 16'h0000); // R14 R19
               st_ff <= tttc_pkg::ST_IDLE;
            end
            default: st_ff <= tttc_pkg::ST_IDLE;
         endcase
      end
   end

   // busy status for software, one cycle behind the state machine
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= (st_ff != tttc_pkg::ST_IDLE);
      end
   end

   assign mem_req = req_ff;
   assign cpu_irq = irq_ff;

   ////////////////////////////////////////////////////////////////////////
   // register read, data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_ff <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            tttc_pkg::ADDR_START: rdata_ff <= {14'h0000, run_ff};
            tttc_pkg::ADDR_CSR0: rdata_ff <= {8'h00, flag_ff, ie_ff,
               4'h0, cks_ff};
            tttc_pkg::ADDR_CNT0: rdata_ff <= cnt;
            tttc_pkg::ADDR_COR0: rdata_ff <= cor_ff;
            tttc_pkg::ADDR_STBY1: rdata_ff <= stby1_ff;
            tttc_pkg::ADDR_STBY2: rdata_ff <= stby2_ff;
            tttc_pkg::ADDR_DBASE: rdata_ff <= dbase_ff;
            tttc_pkg::ADDR_VEC: rdata_ff <= vec_ff;
            tttc_pkg::ADDR_XSTAT: rdata_ff <= {15'h0000, busy_ff};
            default: rdata_ff <= 16'h0000;
         endcase
      end else begin
         rdata_ff <= 16'h0000;
      end
   end
   assign reg_rdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////
   property p_ptr;
      @(posedge clk) disable iff (!rst_n)
      (st_ff == tttc_pkg::ST_IDLE && act) |=>
         mem_req.rd && mem_req.addr == {$past(dbase_ff), $past(vec_ff)};
   endproperty
   a_ptr: assert property (p_ptr) else $error("bad descriptor pointer"); // R3

   property p_order;
      @(posedge clk) disable iff (!rst_n)
      (st_ff == tttc_pkg::ST_IDLE && act) |=> ##1
         mem_req.addr == rf_ff + 32'h2 ##1 mem_req.addr == rf_ff + 32'h8
         ##1 mem_req.addr == rf_ff + 32'hA ##1 mem_req.addr == rf_ff + 32'hC
         ##1 mem_req.addr == rf_ff + 32'hE ##1 mem_req.addr == src_ff;
   endproperty
   a_order: assert property (p_order) else $error("descriptor order"); // R4

   property p_irq;
      @(posedge clk) disable iff (!rst_n)
      cpu_irq |-> count_ff == 16'h0000 && $past(st_ff) == tttc_pkg::ST_WBE;
   endproperty
   a_irq: assert property (p_irq) else $error("early cpu interrupt"); // R14

   property p_gate;
      @(posedge clk) disable iff (!rst_n)
      (st_ff == tttc_pkg::ST_IDLE && match && !ie_ff) |=>
         st_ff == tttc_pkg::ST_IDLE;
   endproperty
   a_gate: assert property (p_gate) else $error("disabled activation"); // R9

   property p_flag_set;
      @(posedge clk) disable iff (!rst_n)
      match |=> flag_ff;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set"); // R8

   property p_count_wb;
      @(posedge clk) disable iff (!rst_n)
      (st_ff == tttc_pkg::ST_WBM) |=> mem_req.wr && mem_req.wdata == count_ff
         && mem_req.addr == rf_ff + tttc_pkg::OFS_COUNT;
   endproperty
   a_count_wb: assert property (p_count_wb) else $error("count lost"); // R17

   property p_asleep;
      @(posedge clk) disable iff (!rst_n)
      (st_ff == tttc_pkg::ST_IDLE && !xfer_awake) |=>
         st_ff == tttc_pkg::ST_IDLE;
   endproperty
   a_asleep: assert property (p_asleep) else $error("woke in standby"); // R15
endmodule : tttc_top

// >>> tttc_ram_model.sv
`timescale 1ns/1ps
module tttc_ram_model (
   // clock
   input wire logic clk,
   // request from the controller
   input wire tttc_pkg::mem_req_t mem_req,
   // answer
   output logic [15:0] mem_rdata
);
   logic [7:0] mem [0:511];
   logic [8:0] a;

   assign a = mem_req.addr[8:0];
   initial mem_rdata = 16'h0000;

   ////////////////////////////////////////////////////////////////////
   // big-endian words; data valid only the cycle after rd, otherwise
   // the inverse of the last value so a late sample never matches
   always @(posedge clk) begin
      if (mem_req.rd) begin
         mem_rdata <= {mem[{a[8:1], 1'b0}], mem[{a[8:1], 1'b1}]};
      end else begin
         mem_rdata <= ~mem_rdata;
      end
      // odd address takes only the low lane, even takes the whole word
      if (mem_req.wr && a[0]) begin
         mem[a] <= mem_req.wdata[7:0];
      end else if (mem_req.wr) begin
         mem[a] <= mem_req.wdata[15:8];
         mem[a + 9'h001] <= mem_req.wdata[7:0];
      end
   end
endmodule : tttc_ram_model

// >>> test_tttc_top.sv
`timescale 1ns/1ps
module test_tttc_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] reg_addr = 32'h0;
   logic [15:0] reg_wdata = 16'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   tttc_pkg::mem_req_t mem_req;
   logic [15:0] mem_rdata;
   logic cpu_irq;
   int error_cnt = 0;
   int cmp_count = 0;
   int rd_cnt = 0;
   int irq_cnt = 0;
   logic [31:0] rd_log [0:31];
   logic [15:0] v;
   logic [15:0] w;
   logic [31:0] rows_a [0:9];
   logic [15:0] rows_d [0:9];
   logic [15:0] rows_e [0:9];

   always #4 clk = ~clk;

   tttc_top u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rdata(mem_rdata),
      .cpu_irq(cpu_irq));
   tttc_ram_model u_ram (.clk(clk), .mem_req(mem_req),
      .mem_rdata(mem_rdata));

   ////////////////////////////////////////////////////////////////////
   // watch the ram port and the cpu request
   always @(posedge clk) begin
      if (mem_req.rd === 1'b1) begin
         if (rd_cnt < 32) rd_log[rd_cnt] <= mem_req.addr;
         rd_cnt <= rd_cnt + 1;
      end
      if (cpu_irq === 1'b1) irq_cnt <= irq_cnt + 1;
   end

   task automatic chk16(input string n, input logic [15:0] e,
      input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk16

   task automatic chk32(input string n, input logic [31:0] e,
      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk32

   // one idle edge first, so a strobe is never set twice in a step
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////
   initial begin
      // rows: address, value written, value read back
      rows_a = '{tttc_pkg::ADDR_STBY1, tttc_pkg::ADDR_STBY2,
         tttc_pkg::ADDR_COR0, tttc_pkg::ADDR_DBASE, tttc_pkg::ADDR_VEC,
         tttc_pkg::ADDR_START, tttc_pkg::ADDR_CSR0, tttc_pkg::ADDR_CNT0,
         32'hFFFF8000, tttc_pkg::ADDR_XSTAT};
      rows_d = '{16'h0000, 16'h0000, 16'h0002, 16'h1234, 16'h0010,
         16'h0002, 16'h0043, 16'h0001, 16'h5555, 16'hFFFF};
      rows_e = '{16'h0000, 16'h0000, 16'h0002, 16'h1234, 16'h0010,
         16'h0002, 16'h0043, 16'h0001, 16'h0000, 16'h0000};
      // descriptor and source bytes placed before any activation
      u_ram.mem[9'h010] = 8'hA0;
      u_ram.mem[9'h011] = 8'h00;
      u_ram.mem[9'h012] = 8'h00;
      u_ram.mem[9'h013] = 8'h03;
      u_ram.mem[9'h018] = 8'h00;
      u_ram.mem[9'h019] = 8'h00;
      u_ram.mem[9'h01A] = 8'h00;
      u_ram.mem[9'h01B] = 8'h60;
      u_ram.mem[9'h01C] = 8'h00;
      u_ram.mem[9'h01D] = 8'h00;
      u_ram.mem[9'h01E] = 8'h00;
      u_ram.mem[9'h01F] = 8'h81;
      u_ram.mem[9'h060] = 8'h11;
      u_ram.mem[9'h061] = 8'h22;
      u_ram.mem[9'h062] = 8'h33;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         wr(rows_a[i], rows_d[i]);
         rd(rows_a[i], v);
         chk16("reg readback", rows_e[i], v);
      end
      $display("test rows done");

      // match without interrupt enable: flag only, no transfer
      wr(tttc_pkg::ADDR_CSR0, 16'h0000);
      wr(tttc_pkg::ADDR_START, 16'h0001);
      repeat (100) @(posedge clk);
      rd(tttc_pkg::ADDR_CSR0, v);
      chk16("match flag", 16'h0080, v);
      chk16("reads while masked", 16'h0, 16'(rd_cnt));
      rd(tttc_pkg::ADDR_CNT0, v);
      chk16("count bounded", 16'h1, 16'(v <= 16'h0002));
      wr(tttc_pkg::ADDR_START, 16'h0000);
      rd(tttc_pkg::ADDR_CNT0, v);
      repeat (50) @(posedge clk);
      rd(tttc_pkg::ADDR_CNT0, w);
      chk16("stopped count", v, w);
      $display("test masked done");

      // three byte transfers, cpu request only after the last one
      wr(tttc_pkg::ADDR_CSR0, 16'h0040);
      wr(tttc_pkg::ADDR_CNT0, 16'h0000);
      wr(tttc_pkg::ADDR_START, 16'h0001);
      for (int i = 0; i < 2000 && irq_cnt == 0; i++) @(posedge clk);
      wr(tttc_pkg::ADDR_START, 16'h0000);
      repeat (40) @(posedge clk);
      chk16("irq pulses", 16'h1, 16'(irq_cnt));
      chk16("ram reads", 16'd21, 16'(rd_cnt));
      chk32("pointer", 32'h12340010, rd_log[0]);
      chk32("count word", 32'h12340012, rd_log[1]);
      chk32("src hi", 32'h12340018, rd_log[2]);
      chk32("src lo", 32'h1234001A, rd_log[3]);
      chk32("dst hi", 32'h1234001C, rd_log[4]);
      chk32("dst lo", 32'h1234001E, rd_log[5]);
      chk32("src byte", 32'h00000060, rd_log[6]);
      chk32("src byte 3", 32'h00000062, rd_log[20]);
      chk16("dst 0 1", 16'h1122, {u_ram.mem[9'h081], u_ram.mem[9'h082]});
      chk16("dst 2", 16'h0033, {8'h00, u_ram.mem[9'h083]});
      chk16("count back", 16'h0000,
         {u_ram.mem[9'h012], u_ram.mem[9'h013]});
      chk16("src back", 16'h0063,
         {u_ram.mem[9'h01A], u_ram.mem[9'h01B]});
      chk16("dst back", 16'h0084,
         {u_ram.mem[9'h01E], u_ram.mem[9'h01F]});
      $display("test transfer done");

      // slowest count rate: two or three counts in 1300 cycles
      wr(tttc_pkg::ADDR_CSR0, 16'h0003);
      wr(tttc_pkg::ADDR_COR0, 16'h0100);
      wr(tttc_pkg::ADDR_CNT0, 16'h0000);
      wr(tttc_pkg::ADDR_START, 16'h0001);
      repeat (1300) @(posedge clk);
      rd(tttc_pkg::ADDR_CNT0, v);
      chk16("div 512", 16'h1, 16'(v >= 16'h2 && v <= 16'h3));
      $display("test prescale done");

      // second reset in mid-run, then register reset values
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      chk16("irq in reset", 16'h0, {15'h0, cpu_irq});
      chk16("mem rd in reset", 16'h0, {15'h0, mem_req.rd});
      rst_n <= 1'b1;
      rd(tttc_pkg::ADDR_STBY1, v);
      chk16("stby1 rst", tttc_pkg::STBY1_RST, v);
      rd(tttc_pkg::ADDR_STBY2, v);
      chk16("stby2 rst", tttc_pkg::STBY2_RST, v);
      rd(tttc_pkg::ADDR_COR0, v);
      chk16("cor rst", tttc_pkg::COR_RST, v);
      rd(tttc_pkg::ADDR_DBASE, v);
      chk16("dbase rst", tttc_pkg::DBASE_RST, v);
      rd(tttc_pkg::ADDR_VEC, v);
      chk16("vec rst", tttc_pkg::VEC_RST, v);
      $display("test reset done");

      // only one of the two controller standby bits cleared
      wr(tttc_pkg::ADDR_STBY2, 16'h0000);
      wr(tttc_pkg::ADDR_STBY1, 16'h0100);
      wr(tttc_pkg::ADDR_COR0, 16'h0002);
      wr(tttc_pkg::ADDR_CSR0, 16'h0040);
      v = 16'(rd_cnt);
      wr(tttc_pkg::ADDR_START, 16'h0001);
      repeat (100) @(posedge clk);
      wr(tttc_pkg::ADDR_START, 16'h0000);
      chk16("reads in standby", v, 16'(rd_cnt));
      rd(tttc_pkg::ADDR_CSR0, v);
      chk16("timer awake", 16'h00C0, v);
      $display("test standby done");
      report_and_stop();
   end
endmodule : test_tttc_top
